/* rtl/sdp_pkg.sv */
package sdp_pkg;

    // Word and symbol geometry
    localparam int WORD_W = 20;
    localparam int HALF_W = 10;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 5;
    localparam int TX_K_LO_BIT = 16;
    localparam int TX_K_HI_BIT = 17;

    // Bit counter marks, one bit per ref_clk
    localparam logic [CNT_W-1:0] WORD_LAST = 5'h13;
    localparam logic [CNT_W-1:0] HALF_LAST = 5'h09;
    localparam logic [CNT_W-1:0] WORD_MID = 5'h0A;
    localparam logic [CNT_W-1:0] HALF_MID = 5'h05;
    localparam logic [CNT_W-1:0] RESYNC_NEXT = 5'h0A;

    // Transmit buffer
    localparam int FIFO_DEPTH = 4;

    // Idle comma K28.5, bit 0 goes out first
    localparam logic [HALF_W-1:0] COMMA_NEG = 10'h17C;
    localparam logic [HALF_W-1:0] COMMA_POS = 10'h283;
    // Comma run abcdeif as it lands in the deserializer
    localparam logic [6:0] COMMA_SEQ_NEG = 7'h7C;
    localparam logic [6:0] COMMA_SEQ_POS = 7'h03;

    // Code tables, abcdei and fghj with a at the msb, negative disparity form
    localparam logic [5:0] K28_6B = 6'h0F;
    localparam logic [3:0] ALT7_4B = 4'h7;
    localparam logic [5:0] TAB6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B
    };
    localparam logic [3:0] TAB4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE
    };

    // Byte shown for an undecodable symbol
    localparam logic [BYTE_W-1:0] DEC_ERR_BYTE = 8'hFE;

endpackage

/* rtl/sdp_sym_if.sv */
`timescale 1ns/1ps

interface sdp_sym_if;
    logic [sdp_pkg::BYTE_W-1:0] byte_v;
    logic k_flag;
    logic [sdp_pkg::HALF_W-1:0] code;
    logic rd_in;
    logic rd_out;
    logic err;

    modport enc_mp (input byte_v, input k_flag, input rd_in, output code, output rd_out);
    modport dec_mp (input code, output byte_v, output k_flag, output err);
endinterface

/* rtl/sdp_enc.sv */
`timescale 1ns/1ps

module sdp_enc (
    // Byte in, symbol out
    sdp_sym_if.enc_mp sym
);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] t6;
    logic [5:0] c6;
    logic [3:0] t4;
    logic [3:0] c4;
    logic rd_mid;
    logic alt;
    logic inv4;

    always_comb
    begin
        x = sym.byte_v[4:0];
        y = sym.byte_v[7:5];
        t6 = (sym.k_flag && x == 5'h1C) ? sdp_pkg::K28_6B : sdp_pkg::TAB6[x];
        c6 = (sym.rd_in && (($countones(t6) != 3) || (x == 5'h07 && !sym.k_flag))) ? ~t6 : t6;
        rd_mid = ($countones(t6) != 3) ? !sym.rd_in : sym.rd_in;
        // Alternate x.7 avoids a run of five inside the symbol
        if (sym.k_flag)
        begin
            alt = (y == 3'h7);
        end
        else if (rd_mid)
        begin
            alt = (y == 3'h7) && (x == 5'h0B || x == 5'h0D || x == 5'h0E);
        end
        else
        begin
            alt = (y == 3'h7) && (x == 5'h11 || x == 5'h12 || x == 5'h14);
        end
        t4 = alt ? sdp_pkg::ALT7_4B : sdp_pkg::TAB4[y];
        if (rd_mid)
        begin
            inv4 = ($countones(t4) != 2) || (y == 3'h3);
        end
        else
        begin
            inv4 = sym.k_flag && ($countones(t4) == 2) && (y != 3'h3);
        end
        c4 = inv4 ? ~t4 : t4;
        sym.rd_out = ($countones(t4) != 2) ? !rd_mid : rd_mid;
        for (int i = 0; i < 6; i++)
        begin
            sym.code[i] = c6[5-i];
        end
        for (int i = 0; i < 4; i++)
        begin
            sym.code[6+i] = c4[3-i];
        end
    end
endmodule

/* rtl/sdp_dec.sv */
`timescale 1ns/1ps

module sdp_dec (
    // Symbol in, byte out
    sdp_sym_if.dec_mp sym
);
    logic [5:0] s6;
    logic [3:0] s4;
    logic [4:0] x;
    logic [2:0] y;
    logic hit6;
    logic hit4;
    logic is28;
    logic alt;

    // Disparity is not policed; only unknown symbols are flagged
    always_comb
    begin
        s6 = '0;
        s4 = '0;
        for (int i = 0; i < 6; i++)
        begin
            s6[5-i] = sym.code[i];
        end
        for (int i = 0; i < 4; i++)
        begin
            s4[3-i] = sym.code[6+i];
        end
        is28 = (s6 == sdp_pkg::K28_6B) || (s6 == ~sdp_pkg::K28_6B);
        if (s6 == ~sdp_pkg::K28_6B)
        begin
            s4 = ~s4;
        end
        hit6 = is28;
        x = is28 ? 5'h1C : 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (s6 == sdp_pkg::TAB6[i] || (s6 == ~sdp_pkg::TAB6[i]
                && ($countones(sdp_pkg::TAB6[i]) != 3 || i == 7)))
            begin
                x = i[4:0];
                hit6 = 1'b1;
            end
        end
        alt = (s4 == sdp_pkg::ALT7_4B) || (s4 == ~sdp_pkg::ALT7_4B);
        hit4 = alt;
        y = alt ? 3'h7 : 3'h0;
        for (int j = 0; j < 8; j++)
        begin
            if (s4 == sdp_pkg::TAB4[j] || (s4 == ~sdp_pkg::TAB4[j]
                && ($countones(sdp_pkg::TAB4[j]) != 2 || j == 3)))
            begin
                y = j[2:0];
                hit4 = 1'b1;
            end
        end
        sym.err = !(hit6 && hit4);
        sym.k_flag = is28 || (alt && (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));
        sym.byte_v = sym.err ? sdp_pkg::DEC_ERR_BYTE : {y, x};
    end
endmodule

/* rtl/sdp_datapath.sv */
`timescale 1ns/1ps

// Contract
// - Full rate: 20-bit word per tx clock serialized
// - Full rate: receive 20-bit words, all lines
// - Coded full rate: 16 data, 2 control
// - Coded full rate: 16 data, 2 status
// - Half rate: lower ten transmit bits only
// - Half rate coded: 8 data, 1 control
// - Half rate receive: lower ten or 8+1
// - Loopback feeds serializer into deserializer
// - Reset: rx clock low, outputs released
// - Serial output released while loopback enabled
// - Transmitter disabled releases serial output
// - Serial rate ten or twenty bits per word
// - Transmit FIFO decouples tx clock domain
// - Transmit and receive rates set independently
// - Low byte first, lsb first
module sdp_datapath #(
    parameter int FIFO_DEPTH = sdp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input logic ref_clk,
    input logic rst_n,
    // Static configuration
    input logic tx_half_rate,
    input logic rx_half_rate,
    input logic tx_code_en,
    input logic rx_code_en,
    input logic tx_disable,
    input logic loopback_enable,
    // Parallel transmit side
    input logic tx_clk,
    input logic [sdp_pkg::WORD_W-1:0] txd,
    output logic tx_fifo_overflow,
    // Serial line
    output logic serial_out_pos,
    output logic serial_out_neg,
    output logic serial_out_oe,
    input logic serial_in_pos,
    input logic serial_in_neg,
    // Parallel receive side
    output logic rx_clk,
    output logic [sdp_pkg::WORD_W-1:0] rxd,
    output logic [sdp_pkg::WORD_W-1:0] rxd_oe
);
    localparam int W = sdp_pkg::WORD_W;
    localparam int H = sdp_pkg::HALF_W;
    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam logic [PTR_W:0] FIFO_FULL = (PTR_W+1)'(FIFO_DEPTH);

    // Input synchronisers
    logic [2:0] tck_s_q;
    logic [2:0] tck_s_d;
    logic tck_lvl_q;
    logic tck_lvl_d;
    logic [W-1:0] txd_s1_q;
    logic [W-1:0] txd_s2_q;
    logic [W-1:0] txd_s3_q;
    logic [2:0] sin_p_s_q;
    logic [2:0] sin_p_s_d;
    logic [2:0] sin_n_s_q;
    logic [2:0] sin_n_s_d;
    logic tck_edge;

    // Transmit state
    logic [W-1:0] mem_q [FIFO_DEPTH];
    logic [W-1:0] mem_d [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] wr_d;
    logic [PTR_W-1:0] rd_q;
    logic [PTR_W-1:0] rd_d;
    logic [PTR_W:0] cnt_q;
    logic [PTR_W:0] cnt_d;
    logic [W-1:0] sh_q;
    logic [W-1:0] sh_d;
    logic [sdp_pkg::CNT_W-1:0] bit_q;
    logic [sdp_pkg::CNT_W-1:0] bit_d;
    logic tx_rd_q;
    logic tx_rd_d;
    logic ovf_q;
    logic ovf_d;
    logic sout_p_q;
    logic sout_p_d;
    logic sout_n_q;
    logic sout_n_d;
    logic sout_oe_q;
    logic sout_oe_d;
    logic [sdp_pkg::CNT_W-1:0] tx_last;
    logic load;
    logic empty;
    logic rd_a;
    logic push;
    logic [W-1:0] cap_word;

    // Receive state
    logic rx_line_q;
    logic rx_line_d;
    logic [W-1:0] rsh_q;
    logic [W-1:0] rsh_d;
    logic [sdp_pkg::CNT_W-1:0] rcnt_q;
    logic [sdp_pkg::CNT_W-1:0] rcnt_d;
    logic [W-1:0] rxd_q;
    logic [W-1:0] rxd_d;
    logic [W-1:0] rxd_oe_q;
    logic [W-1:0] rxd_oe_d;
    logic rx_clk_q;
    logic rx_clk_d;
    logic [sdp_pkg::CNT_W-1:0] rx_last;
    logic bit_in;
    logic comma_hit;
    logic aligned;
    logic done;

    sdp_sym_if enc_lo_if ();
    sdp_sym_if enc_hi_if ();
    sdp_sym_if dec_lo_if ();
    sdp_sym_if dec_hi_if ();

    sdp_enc u_enc_lo (.sym(enc_lo_if));
    sdp_enc u_enc_hi (.sym(enc_hi_if));
    sdp_dec u_dec_lo (.sym(dec_lo_if));
    sdp_dec u_dec_hi (.sym(dec_hi_if));

    // Synchroniser chains, first stage read only by the second
    always_comb
    begin
        tck_s_d = {tck_s_q[1:0], tx_clk};
        sin_p_s_d = {sin_p_s_q[1:0], serial_in_pos};
        sin_n_s_d = {sin_n_s_q[1:0], serial_in_neg};
        tck_lvl_d = (tck_s_q[1] == tck_s_q[2]) ? tck_s_q[2] : tck_lvl_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tck_s_q <= '0;
            sin_p_s_q <= '0;
            sin_n_s_q <= '0;
            tck_lvl_q <= 1'b0;
            txd_s1_q <= '0;
            txd_s2_q <= '0;
            txd_s3_q <= '0;
        end
        else
        begin
            tck_s_q <= tck_s_d;
            sin_p_s_q <= sin_p_s_d;
            sin_n_s_q <= sin_n_s_d;
            tck_lvl_q <= tck_lvl_d;
            txd_s1_q <= txd;
            txd_s2_q <= txd_s1_q;
            txd_s3_q <= txd_s2_q;
        end
    end

    // Rising tx clock seen once stages two and three agree
    assign tck_edge = (tck_s_q[1] == tck_s_q[2]) && tck_s_q[2] && !tck_lvl_q;

    // Word length sets bits per word
    assign tx_last = tx_half_rate ? sdp_pkg::HALF_LAST : sdp_pkg::WORD_LAST;
    assign load = (bit_q == tx_last);
    assign empty = (cnt_q == '0);
    // Half-rate idle comma flips disparity ahead of a same-cycle capture
    assign rd_a = (load && empty && tx_code_en && tx_half_rate) ? !tx_rd_q : tx_rd_q;
    assign push = tck_edge && (cnt_q != FIFO_FULL);

    // Two bytes with their control flags
    assign enc_lo_if.byte_v = txd_s3_q[sdp_pkg::BYTE_W-1:0];
    assign enc_lo_if.k_flag = txd_s3_q[sdp_pkg::TX_K_LO_BIT];
    assign enc_lo_if.rd_in = rd_a;
    assign enc_hi_if.byte_v = txd_s3_q[2*sdp_pkg::BYTE_W-1:sdp_pkg::BYTE_W];
    assign enc_hi_if.k_flag = txd_s3_q[sdp_pkg::TX_K_HI_BIT];
    assign enc_hi_if.rd_in = enc_lo_if.rd_out;

    always_comb
    begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        ovf_d = 1'b0;
        tx_rd_d = rd_a;
        sh_d = {1'b0, sh_q[W-1:1]};
        bit_d = bit_q + 5'h01;
        if (tx_code_en)
        begin
            // Half rate codes the low byte only
            cap_word = tx_half_rate ? {{H{1'b0}}, enc_lo_if.code} : {enc_hi_if.code, enc_lo_if.code};
        end
        else
        begin
            // Half rate takes the lower ten lines
            cap_word = tx_half_rate ? {{H{1'b0}}, txd_s3_q[H-1:0]} : txd_s3_q;
        end
        // Capture one word per tx clock
        if (tck_edge)
        begin
            if (push)
            begin
                mem_d[wr_q] = cap_word;
                wr_d = wr_q + PTR_W'(1);
                if (tx_code_en)
                begin
                    tx_rd_d = tx_half_rate ? enc_lo_if.rd_out : enc_hi_if.rd_out;
                end
            end
            else
            begin
                ovf_d = 1'b1;
            end
        end
        // Serializer drains the buffer on its own clock
        if (load)
        begin
            bit_d = '0;
            if (!empty)
            begin
                sh_d = mem_q[rd_q];
                rd_d = rd_q + PTR_W'(1);
            end
            else if (tx_code_en && tx_half_rate)
            begin
                sh_d = {{H{1'b0}}, tx_rd_q ? sdp_pkg::COMMA_POS : sdp_pkg::COMMA_NEG};
            end
            else if (tx_code_en)
            begin
                sh_d = {tx_rd_q ? sdp_pkg::COMMA_NEG : sdp_pkg::COMMA_POS,
                        tx_rd_q ? sdp_pkg::COMMA_POS : sdp_pkg::COMMA_NEG};
            end
            else
            begin
                sh_d = '0;
            end
        end
        cnt_d = cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(load && !empty);
        // Bit zero of the word leaves first
        sout_p_d = sh_q[0];
        sout_n_d = !sh_q[0];
        sout_oe_d = !loopback_enable && !tx_disable;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mem_q <= '{default: '0};
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            sh_q <= '0;
            bit_q <= '0;
            tx_rd_q <= 1'b0;
            ovf_q <= 1'b0;
            sout_p_q <= 1'b0;
            sout_n_q <= 1'b0;
            sout_oe_q <= 1'b0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            tx_rd_q <= tx_rd_d;
            ovf_q <= ovf_d;
            sout_p_q <= sout_p_d;
            sout_n_q <= sout_n_d;
            sout_oe_q <= sout_oe_d;
        end
    end

    // Receive length from its own rate input
    assign rx_last = rx_half_rate ? sdp_pkg::HALF_LAST : sdp_pkg::WORD_LAST;
    assign bit_in = loopback_enable ? sh_q[0] : rx_line_q;
    assign dec_lo_if.code = rx_half_rate ? rsh_d[W-1:H] : rsh_d[H-1:0];
    assign dec_hi_if.code = rsh_d[W-1:H];

    always_comb
    begin
        // Equal legs carry no data; the last bit is held
        rx_line_d = (sin_p_s_q[2] != sin_n_s_q[2]) ? sin_p_s_q[2] : rx_line_q;
        rsh_d = {bit_in, rsh_q[W-1:1]};
        comma_hit = rx_code_en && (rsh_d[W-4:H] == sdp_pkg::COMMA_SEQ_NEG
                    || rsh_d[W-4:H] == sdp_pkg::COMMA_SEQ_POS);
        aligned = (rcnt_q == sdp_pkg::HALF_LAST) || (rcnt_q == sdp_pkg::WORD_LAST);
        done = (rcnt_q == rx_last);
        rcnt_d = rcnt_q + 5'h01;
        // Comma realigns; a full word starts with its low byte
        if (comma_hit && !aligned)
        begin
            done = rx_half_rate;
            rcnt_d = sdp_pkg::RESYNC_NEXT;
        end
        if (done)
        begin
            rcnt_d = '0;
        end
        rxd_d = rxd_q;
        if (done && rx_code_en && rx_half_rate)
        begin
            // Eight data bits plus one status
            rxd_d = '0;
            rxd_d[sdp_pkg::BYTE_W-1:0] = dec_lo_if.byte_v;
            rxd_d[sdp_pkg::TX_K_LO_BIT] = dec_lo_if.k_flag || dec_lo_if.err;
        end
        else if (done && rx_code_en)
        begin
            // Sixteen data bits plus two status
            rxd_d = '0;
            rxd_d[2*sdp_pkg::BYTE_W-1:0] = {dec_hi_if.byte_v, dec_lo_if.byte_v};
            rxd_d[sdp_pkg::TX_K_LO_BIT] = dec_lo_if.k_flag || dec_lo_if.err;
            rxd_d[sdp_pkg::TX_K_HI_BIT] = dec_hi_if.k_flag || dec_hi_if.err;
        end
        else if (done && rx_half_rate)
        begin
            // Raw symbol on the lower ten lines
            rxd_d = {{H{1'b0}}, rsh_d[W-1:H]};
        end
        else if (done)
        begin
            // Raw word on all twenty lines
            rxd_d = rsh_d;
        end
        // Top two lines are released when decoding
        rxd_oe_d = rx_code_en ? {2'b00, {(W-2){1'b1}}} : {W{1'b1}};
        // Data changes on the falling edge, stable at the rise
        rx_clk_d = (rcnt_d >= (rx_half_rate ? sdp_pkg::HALF_MID : sdp_pkg::WORD_MID));
    end

    always_ff @(posedge ref_clk)
    begin
        // Reset holds rx clock low, all released
        if (!rst_n)
        begin
            rx_line_q <= 1'b0;
            rsh_q <= '0;
            rcnt_q <= '0;
            rxd_q <= '0;
            rxd_oe_q <= '0;
            rx_clk_q <= 1'b0;
        end
        else
        begin
            rx_line_q <= rx_line_d;
            rsh_q <= rsh_d;
            rcnt_q <= rcnt_d;
            rxd_q <= rxd_d;
            rxd_oe_q <= rxd_oe_d;
            rx_clk_q <= rx_clk_d;
        end
    end

    assign tx_fifo_overflow = ovf_q;
    assign serial_out_pos = sout_p_q;
    assign serial_out_neg = sout_n_q;
    assign serial_out_oe = sout_oe_q;
    assign rx_clk = rx_clk_q;
    assign rxd = rxd_q;
    assign rxd_oe = rxd_oe_q;
endmodule

/* verification/sdp_datapath_chk.sv */
`timescale 1ns/1ps

module sdp_datapath_chk #(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input logic ref_clk,
    input logic rst_n,
    // Static configuration
    input logic tx_half_rate,
    input logic rx_half_rate,
    input logic tx_code_en,
    input logic rx_code_en,
    input logic tx_disable,
    input logic loopback_enable,
    // Parallel transmit side
    input logic tx_clk,
    input logic [sdp_pkg::WORD_W-1:0] txd,
    input logic tx_fifo_overflow,
    // Serial line
    input logic serial_out_pos,
    input logic serial_out_neg,
    input logic serial_out_oe,
    input logic serial_in_pos,
    input logic serial_in_neg,
    // Parallel receive side
    input logic rx_clk,
    input logic [sdp_pkg::WORD_W-1:0] rxd,
    input logic [sdp_pkg::WORD_W-1:0] rxd_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Config settles one edge after reset
    sequence s_loop_held;
        loopback_enable [*2];
    endsequence
    sequence s_off_held;
        tx_disable [*2];
    endsequence
    sequence s_drive_held;
        (!loopback_enable && !tx_disable) [*2];
    endsequence
    sequence s_raw_full_held;
        (!rx_code_en && !rx_half_rate) [*2];
    endsequence

    property p_rst_quiet;
        $rose(rst_n) |-> !serial_out_oe && !rx_clk && rxd_oe == '0 && rxd == '0;
    endproperty
    property p_loop_release;
        s_loop_held |-> !serial_out_oe;
    endproperty
    property p_off_release;
        s_off_held |-> !serial_out_oe;
    endproperty
    property p_drive;
        s_drive_held |-> serial_out_oe;
    endproperty
    property p_diff;
        serial_out_oe |-> serial_out_neg != serial_out_pos;
    endproperty
    property p_ovf_pulse;
        tx_fifo_overflow |=> !tx_fifo_overflow [*2];
    endproperty
    property p_rx_full_drive;
        s_raw_full_held |-> rxd_oe == 20'hF_FFFF;
    endproperty
    property p_rxd_at_low_clk;
        $changed(rxd) |-> !rx_clk;
    endproperty
    property p_coded_top;
        rx_code_en |-> rxd[19:18] == 2'h0 && rxd_oe[19:18] == 2'h0;
    endproperty
    property p_half_coded;
        rx_code_en && rx_half_rate |-> rxd[15:8] == 8'h00;
    endproperty

    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    a_loop_release: assert property (p_loop_release)
        else $error("serial output driven in loopback");
    a_off_release: assert property (p_off_release)
        else $error("serial output driven while disabled");
    a_drive: assert property (p_drive)
        else $error("serial output not driven");
    a_diff: assert property (p_diff)
        else $error("serial pair not complementary");
    a_ovf_pulse: assert property (p_ovf_pulse)
        else $error("overflow pulse too long");
    a_rx_full_drive: assert property (p_rx_full_drive)
        else $error("receive lines not all driven");
    a_rxd_at_low_clk: assert property (p_rxd_at_low_clk)
        else $error("receive word changed with clock high");
    a_coded_top: assert property (p_coded_top)
        else $error("top receive lines not released");
    a_half_coded: assert property (p_half_coded)
        else $error("upper receive byte not zero");
endmodule

bind sdp_datapath sdp_datapath_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_sdp_datapath_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .tx_half_rate(tx_half_rate),
    .rx_half_rate(rx_half_rate), .tx_code_en(tx_code_en), .rx_code_en(rx_code_en),
    .tx_disable(tx_disable), .loopback_enable(loopback_enable), .tx_clk(tx_clk),
    .txd(txd), .tx_fifo_overflow(tx_fifo_overflow), .serial_out_pos(serial_out_pos),
    .serial_out_neg(serial_out_neg), .serial_out_oe(serial_out_oe),
    .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg), .rx_clk(rx_clk),
    .rxd(rxd), .rxd_oe(rxd_oe)
);

/* verification/sdp_mac_model.sv */
`timescale 1ns/1ps

module sdp_mac_model (
    // Parallel transmit side
    output logic tx_clk,
    output logic [19:0] txd
);
    initial
    begin
        tx_clk = 1'h0;
        txd = 20'h0_0000;
    end

    // One clock pulse per word; clock stands still between words
    task automatic send(input logic [19:0] w);
        #3;
        txd = w;
        #20;
        tx_clk = 1'h1;
        #100;
        tx_clk = 1'h0;
        #100;
        // Hold over, stale data must not look valid
        txd = ~w;
    endtask
endmodule

/* verification/sdp_datapath_test.sv */
`timescale 1ns/1ps

module sdp_datapath_test;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic tx_half_rate = 1'h0;
    logic rx_half_rate = 1'h0;
    logic tx_code_en = 1'h0;
    logic rx_code_en = 1'h0;
    logic tx_disable = 1'h0;
    logic loopback_enable = 1'h0;
    logic serial_in_pos = 1'h0;
    logic serial_in_neg = 1'h0;
    logic chk_rx = 1'h0;
    logic tx_clk, tx_fifo_overflow, serial_out_pos, serial_out_neg, serial_out_oe, rx_clk;
    logic [19:0] txd, rxd, rxd_oe;
    logic [8:0] exp_q [$];
    int n_mismatch = 0;
    int n_checks = 0;
    int n_ovf = 0;
    int cycles = 0;

    always #12.5 ref_clk = ~ref_clk;

    sdp_datapath #(.FIFO_DEPTH(2)) u_sdp_datapath (
        .ref_clk(ref_clk), .rst_n(rst_n), .tx_half_rate(tx_half_rate),
        .rx_half_rate(rx_half_rate), .tx_code_en(tx_code_en), .rx_code_en(rx_code_en),
        .tx_disable(tx_disable), .loopback_enable(loopback_enable), .tx_clk(tx_clk),
        .txd(txd), .tx_fifo_overflow(tx_fifo_overflow), .serial_out_pos(serial_out_pos),
        .serial_out_neg(serial_out_neg), .serial_out_oe(serial_out_oe),
        .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg), .rx_clk(rx_clk),
        .rxd(rxd), .rxd_oe(rxd_oe)
    );
    sdp_mac_model u_sdp_mac_model (.tx_clk(tx_clk), .txd(txd));

    // Cable back to the input; a released line toggles
    always @(negedge ref_clk)
    begin
        serial_in_pos <= serial_out_oe ? serial_out_pos : ~serial_in_pos;
        serial_in_neg <= serial_out_oe ? serial_out_neg : serial_in_pos;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_val(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Sampled away from the launching edge
    always @(negedge ref_clk)
    begin
        cycles++;
        if (tx_fifo_overflow === 1'h1)
            n_ovf++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // Idle comma carries no data
    task automatic take(input logic [8:0] got);
        if (got !== 9'h1BC)
        begin
            if (exp_q.size() == 0)
                check_val("stray byte", 40'h1BC, {31'h0, got});
            else
                check_val("received byte", {31'h0, exp_q.pop_front()}, {31'h0, got});
        end
    endtask

    always @(posedge rx_clk)
    begin
        if (chk_rx)
        begin
            take({rxd[16], rxd[7:0]});
            if (!rx_half_rate)
                take({rxd[17], rxd[15:8]});
        end
    end

    task automatic restart(input logic [5:0] cfg);
        @(negedge ref_clk);
        chk_rx = 1'h0;
        rst_n = 1'h0;
        {tx_half_rate, rx_half_rate, tx_code_en, rx_code_en, tx_disable, loopback_enable} = cfg;
        repeat (4) @(negedge ref_clk);
        check_val("reset outputs", 40'h0, {rxd, rxd_oe});
        check_val("reset clock and enable", 40'h0, {38'h0, rx_clk, serial_out_oe});
        rst_n = 1'h1;
        repeat (60) @(negedge ref_clk);
        check_val("serial enable", {39'h0, !tx_disable && !loopback_enable},
                  {39'h0, serial_out_oe});
        chk_rx = rx_code_en;
    endtask

    task automatic coded_run(input int nw);
        logic [7:0] lo, hi;
        for (int i = 0; i < nw; i++)
        begin
            lo = (i == 0) ? 8'h1C : 8'($urandom);
            hi = 8'($urandom);
            exp_q.push_back({(i == 0), lo});
            if (!tx_half_rate)
                exp_q.push_back({1'h0, hi});
            // Top two lines are noise the device must ignore
            u_sdp_mac_model.send({2'($urandom), 1'h0, (i == 0), hi, lo});
            repeat (tx_half_rate ? 6 : 14) @(negedge ref_clk);
        end
        repeat (80) @(negedge ref_clk);
        check_val("bytes outstanding", 40'h0, 40'(exp_q.size()));
    endtask

    function automatic logic [39:0] exp_serial(input logic [39:0] w, input int n);
        return w & ((40'h1 << n) - 40'h1);
    endfunction

    task automatic raw_word(input int n);
        logic [39:0] got, w;
        logic [19:0] rx_w;
        int t;
        w = {20'h0_0000, 20'($urandom) | 20'h0_0001};
        got = '0;
        rx_w = '0;
        t = 0;
        fork
            u_sdp_mac_model.send(w[19:0]);
            begin
                while (serial_out_pos !== 1'h1 && t < 100)
                begin
                    @(negedge ref_clk);
                    t++;
                end
                for (int i = 0; i < 2 * n; i++)
                begin
                    got[i] = serial_out_pos;
                    // Looped word stands a whole word period from here
                    if (i == n)
                        rx_w = rxd;
                    @(negedge ref_clk);
                end
            end
        join
        check_val("serial word", exp_serial(w, n), got);
        if (loopback_enable)
            check_val("loop word", exp_serial(w, n), {20'h0_0000, rx_w});
    endtask

    initial
    begin
        void'($urandom(76373));
        restart(6'h0D);
        coded_run(12);
        restart(6'h1C);
        coded_run(12);
        restart(6'h3D);
        coded_run(12);
        restart(6'h00);
        repeat (4) raw_word(20);
        check_val("early overflow", 40'h0, 40'(n_ovf));
        repeat (8) u_sdp_mac_model.send(20'($urandom));
        repeat (10) @(negedge ref_clk);
        check_val("overflow seen", 40'h1, {39'h0, n_ovf > 0});
        restart(6'h20);
        repeat (4) raw_word(10);
        // Raw loopback keeps both bit counters in step from reset
        restart(6'h01);
        repeat (2) raw_word(20);
        restart(6'h31);
        repeat (2) raw_word(10);
        restart(6'h02);
        u_sdp_mac_model.send(20'h0_0001);
        repeat (30) @(negedge ref_clk);
        check_val("disabled enable", 40'h0, {39'h0, serial_out_oe});
        report_and_stop();
    end
endmodule
